//--- design/lec_pkg.sv
// package for the link error classifier: severities, error slots, codes
// assumes a single core clock domain and synchronous active-high reset
package lec_pkg;

    // ------------------------------------------------------------------
    // receive status codes reported per lane
    // ------------------------------------------------------------------
    localparam logic [2:0] LEC_RXS_DECODE    = 3'h4;
    localparam logic [2:0] LEC_RXS_EB_OVER   = 3'h5;
    localparam logic [2:0] LEC_RXS_EB_UNDER  = 3'h6;
    localparam logic [2:0] LEC_RXS_DISPARITY = 3'h7;
    localparam int         LEC_RXS_W         = 3;

    // ------------------------------------------------------------------
    // error slots, one sticky bit each
    // ------------------------------------------------------------------
    localparam int LEC_NERR          = 6;
    localparam int LEC_E_RX_PORT     = 0;
    localparam int LEC_E_BAD_TLP     = 1;
    localparam int LEC_E_BAD_DLLP    = 2;
    localparam int LEC_E_REPLAY_TMO  = 3;
    localparam int LEC_E_REPLAY_ROLL = 4;
    localparam int LEC_E_DL_PROTO    = 5;

    // ------------------------------------------------------------------
    // severity classes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LEC_SEV_NONE     = 2'b00,
        LEC_SEV_CORR     = 2'b01,
        LEC_SEV_NONFATAL = 2'b10,
        LEC_SEV_FATAL    = 2'b11
    } lec_sev_t;

    localparam logic [LEC_NERR-1:0] LEC_STICKY_RST = 6'h00;
    localparam logic [LEC_NERR-1:0] LEC_ALL_ZERO   = 6'h00;

endpackage

//--- design/lec_lane_check.sv
// per-lane receive status screen; one instance per lane
// assumes rxstatus and l0 are already in the core clock domain
`timescale 1ns/100ps
module lec_lane_check
    import lec_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic [LEC_RXS_W-1:0] rxstatus,
    input  wire logic                lane_in_l0,
    output logic                     lane_err
);

    typedef struct packed {
        logic err;
    } lec_lane_st_t;

    lec_lane_st_t st_reg;
    lec_lane_st_t st_next;

    // ------------------------------------------------------------------
    // coding errors count only while the lane is in l0
    // ------------------------------------------------------------------
    always_comb begin
        st_next.err = 1'b0;
        if (lane_in_l0) begin
            unique case (rxstatus)
                LEC_RXS_DECODE, LEC_RXS_DISPARITY:
                    st_next.err = 1'b1;
                LEC_RXS_EB_OVER, LEC_RXS_EB_UNDER:
                    st_next.err = 1'b1;
                default:
                    st_next.err = 1'b0;
            endcase
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign lane_err = st_reg.err;

endmodule

//--- design/lec_classifier.sv
// link error classifier: physical and data link layer error detection
// assumes all event inputs are one-cycle pulses from core_clk logic
`timescale 1ns/100ps
module lec_classifier
    import lec_pkg::*;
#(
    parameter int LANES  = 8,
    parameter int SEQ_W  = 12
)
(
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic [LANES*LEC_RXS_W-1:0] rxstatus,
    input  wire logic [LANES-1:0]         lane_in_l0,
    input  wire logic                     deskew_ovf,
    input  wire logic                     ctrl_sym_bad_lane,
    input  wire logic                     tlp_lcrc_fail,
    input  wire logic                     tlp_seq_err,
    input  wire logic                     dllp_crc_fail,
    input  wire logic                     replay_timeout,
    input  wire logic                     replay_num_roll,
    input  wire logic                     acknak_valid,
    input  wire logic [SEQ_W-1:0]         acked_sequence_number,
    input  wire logic [SEQ_W-1:0]         oldest_unacked_seq,
    input  wire logic [SEQ_W-1:0]         next_tx_seq,
    input  wire logic [LEC_NERR-1:0]      sticky_clear,
    output logic [LEC_NERR-1:0]           err_event,
    output logic [LEC_NERR-1:0]           err_sticky,
    output logic                          err_valid,
    output lec_sev_t                      err_severity,
    output logic                          corr_err,
    output logic                          nonfatal_err,
    output logic                          fatal_err
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // fixed severity of each error slot
    function automatic lec_sev_t sev_of(input int slot);
        if (slot == LEC_E_DL_PROTO) begin
            return LEC_SEV_FATAL;
        end
        return LEC_SEV_CORR;
    endfunction

    // true when seq lies in the unacked window [oldest-1 .. next-1] (mod)
    function automatic logic seq_in_window(
        input logic [SEQ_W-1:0] seq,
        input logic [SEQ_W-1:0] lo,
        input logic [SEQ_W-1:0] hi);
        logic [SEQ_W-1:0] d_seq;
        logic [SEQ_W-1:0] d_hi;
        d_seq = SEQ_W'(seq - lo);
        d_hi  = SEQ_W'(hi - lo);
        return d_seq <= d_hi;
    endfunction

    // ------------------------------------------------------------------
    // per-lane coding checks
    // ------------------------------------------------------------------
    logic [LANES-1:0] lane_err;

    genvar gl;
    generate
        for (gl = 0; gl < LANES; gl++) begin : g_lane
            lec_lane_check u_lane (
                .core_clk   (core_clk),
                .rst        (rst),
                .rxstatus   (rxstatus[gl*LEC_RXS_W +: LEC_RXS_W]),
                .lane_in_l0 (lane_in_l0[gl]),
                .lane_err   (lane_err[gl])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [LEC_NERR-1:0] ev;
        logic [LEC_NERR-1:0] sticky;
        logic                vld;
        lec_sev_t            sev;
        logic                corr;
        logic                nonfatal;
        logic                fatal;
    } lec_st_t;

    lec_st_t st_reg;
    lec_st_t st_next;

    // events of this cycle; lane codes arrive one register stage later
    logic [LEC_NERR-1:0] raw_ev;
    logic [SEQ_W-1:0]    win_lo;
    logic                ack_bad;

    // ------------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------------
    always_comb begin
        // ack of an already-acked packet refers to oldest-1
        win_lo  = SEQ_W'(oldest_unacked_seq - 1'b1);
        ack_bad = acknak_valid &&
                  !seq_in_window(acked_sequence_number, win_lo,
                                 SEQ_W'(next_tx_seq - 1'b1));
        raw_ev                    = LEC_ALL_ZERO;
        raw_ev[LEC_E_RX_PORT]     = (|lane_err)
                                  | deskew_ovf
                                  | ctrl_sym_bad_lane;
        raw_ev[LEC_E_BAD_TLP]     = tlp_lcrc_fail | tlp_seq_err;
        raw_ev[LEC_E_BAD_DLLP]    = dllp_crc_fail;
        raw_ev[LEC_E_REPLAY_TMO]  = replay_timeout;
        raw_ev[LEC_E_REPLAY_ROLL] = replay_num_roll;
        raw_ev[LEC_E_DL_PROTO]    = ack_bad;
    end

    // ------------------------------------------------------------------
    // classification and sticky status
    // ------------------------------------------------------------------
    always_comb begin
        st_next          = st_reg;
        st_next.ev       = raw_ev;
        // set wins over a clear in the same cycle
        st_next.sticky   = (st_reg.sticky & ~sticky_clear)
                         | raw_ev;
        st_next.vld      = |raw_ev;
        st_next.corr     = 1'b0;
        st_next.nonfatal = 1'b0;
        st_next.fatal    = 1'b0;
        st_next.sev      = LEC_SEV_NONE;
        for (int i = 0; i < LEC_NERR; i++) begin
            if (raw_ev[i]) begin
                unique case (sev_of(i))
                    LEC_SEV_CORR:     st_next.corr     = 1'b1;
                    LEC_SEV_NONFATAL: st_next.nonfatal = 1'b1;
                    LEC_SEV_FATAL:    st_next.fatal    = 1'b1;
                    LEC_SEV_NONE:     st_next.corr     = st_next.corr;
                endcase
            end
        end
        // reported severity is the worst one seen this cycle
        if (st_next.fatal) begin
            st_next.sev = LEC_SEV_FATAL;
        end else if (st_next.nonfatal) begin
            st_next.sev = LEC_SEV_NONFATAL;
        end else if (st_next.corr) begin
            st_next.sev = LEC_SEV_CORR;
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_reg        <= '0;
            st_reg.sticky <= LEC_STICKY_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign err_event    = st_reg.ev;
    assign err_sticky   = st_reg.sticky;
    assign err_valid    = st_reg.vld;
    assign err_severity = st_reg.sev;
    assign corr_err     = st_reg.corr;
    assign nonfatal_err = st_reg.nonfatal;
    assign fatal_err    = st_reg.fatal;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_bad_tlp;
        @(posedge core_clk) disable iff (rst)
        (tlp_lcrc_fail || tlp_seq_err)
            |=> err_event[LEC_E_BAD_TLP] && corr_err;
    endproperty
    a_bad_tlp: assert property (p_bad_tlp)
        else $error("bad tlp not flagged correctable");

    property p_bad_dllp;
        @(posedge core_clk) disable iff (rst)
        dllp_crc_fail |=> err_event[LEC_E_BAD_DLLP] && corr_err;
    endproperty
    a_bad_dllp: assert property (p_bad_dllp)
        else $error("bad dllp not flagged");

    property p_replay_tmo;
        @(posedge core_clk) disable iff (rst)
        replay_timeout |=> err_event[LEC_E_REPLAY_TMO] && corr_err;
    endproperty
    a_replay_tmo: assert property (p_replay_tmo)
        else $error("replay timeout not flagged");

    property p_replay_roll;
        @(posedge core_clk) disable iff (rst)
        replay_num_roll |=> err_event[LEC_E_REPLAY_ROLL] && corr_err;
    endproperty
    a_replay_roll: assert property (p_replay_roll)
        else $error("replay rollover not flagged");

    property p_deskew;
        @(posedge core_clk) disable iff (rst)
        (deskew_ovf || ctrl_sym_bad_lane) |=> err_event[LEC_E_RX_PORT];
    endproperty
    a_deskew: assert property (p_deskew)
        else $error("deskew or lane control error not flagged");

    property p_lane0_code;
        @(posedge core_clk) disable iff (rst)
        (lane_in_l0[0] && rxstatus[LEC_RXS_W-1])
            |-> ##2 err_event[LEC_E_RX_PORT];
    endproperty
    a_lane0_code: assert property (p_lane0_code)
        else $error("lane 0 coding error not flagged");

    property p_fatal_proto;
        @(posedge core_clk) disable iff (rst)
        err_event[LEC_E_DL_PROTO]
            |-> fatal_err && err_severity == LEC_SEV_FATAL;
    endproperty
    a_fatal_proto: assert property (p_fatal_proto)
        else $error("protocol error not fatal");

    property p_one_class;
        @(posedge core_clk) disable iff (rst)
        err_valid |-> err_severity != LEC_SEV_NONE && !nonfatal_err;
    endproperty
    a_one_class: assert property (p_one_class)
        else $error("error without a severity class");

    property p_sticky_hold;
        @(posedge core_clk) disable iff (rst)
        (err_sticky[LEC_E_BAD_DLLP] && !sticky_clear[LEC_E_BAD_DLLP])
            |=> err_sticky[LEC_E_BAD_DLLP];
    endproperty
    a_sticky_hold: assert property (p_sticky_hold)
        else $error("sticky bit dropped without clear");

    property p_sticky_set;
        @(posedge core_clk) disable iff (rst)
        err_event[LEC_E_BAD_TLP] |-> err_sticky[LEC_E_BAD_TLP];
    endproperty
    a_sticky_set: assert property (p_sticky_set)
        else $error("sticky bit not set by event");

endmodule

//--- test/lec_phy_model.sv
// model of the per-lane transceiver feeding receive status and link state
// assumes the bench changes its injection controls at the falling edge
`timescale 1ns/100ps
module lec_phy_model
    import lec_pkg::*;
#(
    parameter int LANES = 8
)
(
    input  wire logic [2:0]                  inj_lane,
    input  wire logic [LEC_RXS_W-1:0]        inj_code,
    input  wire logic                        inj_go,
    input  wire logic [LANES-1:0]            l0_mask,
    output logic      [LANES*LEC_RXS_W-1:0]  rxstatus,
    output logic      [LANES-1:0]            lane_in_l0
);
    // ------------------------------------------------------------------
    // status codes: one lane carries the injected code, others report ok
    // ------------------------------------------------------------------
    always_comb begin
        for (int n = 0; n < LANES; n++) begin
            rxstatus[n*LEC_RXS_W +: LEC_RXS_W] =
                (inj_go && inj_lane == n[2:0]) ? inj_code : 3'h0;
        end
    end

    // link state per lane
    assign lane_in_l0 = l0_mask;
endmodule

//--- test/link_error_classifier_tb.sv
// self-checking bench for the link error classifier
// assumes lec_pkg, lec_classifier and lec_phy_model are compiled first
`timescale 1ns/100ps
module link_error_classifier_tb;
    import lec_pkg::*;
    localparam int LANES = 8;
    localparam int SEQ_W = 12;
    localparam int SLOT [7] = '{0, 0, 1, 1, 2, 3, 4};
    logic                 core_clk = 1'b0;
    logic                 rst      = 1'b1;
    logic [6:0]           ev       = 7'h00;
    logic                 ack_go   = 1'b0;
    logic [SEQ_W-1:0]     ack_seq  = 12'h000;
    logic [SEQ_W-1:0]     oldest   = 12'h000;
    logic [SEQ_W-1:0]     nxt      = 12'h000;
    logic [LEC_NERR-1:0]  clr      = 6'h00;
    logic [2:0]           ph_lane  = 3'h5;
    logic [2:0]           ph_code  = 3'h0;
    logic                 ph_go    = 1'b0;
    logic [LANES-1:0]     l0_mask  = 8'hff;
    logic [LANES*3-1:0]   rxstatus;
    logic [LANES-1:0]     lane_in_l0;
    logic [5:0]           err_event;
    logic [5:0]           err_sticky;
    logic                 err_valid;
    lec_sev_t             err_severity;
    logic                 corr_err;
    logic                 nonfatal_err;
    logic                 fatal_err;
    int                   n_errors = 0;
    int                   n_tests  = 0;

    // ------------------------------------------------------------------
    // clock, partner and design
    // ------------------------------------------------------------------
    always #5 core_clk = ~core_clk;

    lec_phy_model #(.LANES(LANES)) phy (
        .inj_lane(ph_lane), .inj_code(ph_code), .inj_go(ph_go),
        .l0_mask(l0_mask), .rxstatus(rxstatus), .lane_in_l0(lane_in_l0));

    lec_classifier #(.LANES(LANES), .SEQ_W(SEQ_W)) dut (
        .core_clk(core_clk), .rst(rst), .rxstatus(rxstatus),
        .lane_in_l0(lane_in_l0), .deskew_ovf(ev[0]),
        .ctrl_sym_bad_lane(ev[1]), .tlp_lcrc_fail(ev[2]),
        .tlp_seq_err(ev[3]), .dllp_crc_fail(ev[4]),
        .replay_timeout(ev[5]), .replay_num_roll(ev[6]),
        .acknak_valid(ack_go), .acked_sequence_number(ack_seq),
        .oldest_unacked_seq(oldest), .next_tx_seq(nxt),
        .sticky_clear(clr), .err_event(err_event),
        .err_sticky(err_sticky), .err_valid(err_valid),
        .err_severity(err_severity), .corr_err(corr_err),
        .nonfatal_err(nonfatal_err), .fatal_err(fatal_err));

    // ------------------------------------------------------------------
    // compare tasks and verdict
    // ------------------------------------------------------------------
    task automatic chk_vec(input logic [5:0] got, input logic [5:0] exp,
                           input string msg);
        n_tests++;
        if (got !== exp) begin
            $display("wrong value at %0t: %s", $time, msg);
            n_errors++;
        end
    endtask

    task automatic chk_sev(input lec_sev_t got, input lec_sev_t exp);
        n_tests++;
        if (got !== exp) begin
            $display("wrong value at %0t: severity", $time);
            n_errors++;
        end
    endtask

    task automatic test_done;
        if (n_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // all pulse outputs against one expected slot set and class
    task automatic expect_out(input logic [5:0] e, input lec_sev_t s);
        chk_vec(err_event, e, "event");
        chk_vec({5'h00, err_valid}, {5'h00, |e}, "valid");
        chk_sev(err_severity, s);
        chk_vec({3'h0, corr_err, nonfatal_err, fatal_err},
                {3'h0, s == LEC_SEV_CORR, 1'b0, s == LEC_SEV_FATAL}, "class");
    endtask

    task automatic clear_all;
        clr = 6'h3f;
        @(negedge core_clk);
        clr = 6'h00;
        chk_vec(err_sticky, 6'h00, "sticky clear");
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        @(negedge core_clk);
        expect_out(6'h00, LEC_SEV_NONE);
        chk_vec(err_sticky, 6'h00, "sticky reset");
    endtask

    // every direct event input, one per cycle, then two at once
    task automatic t_direct;
        for (int i = 0; i < 7; i++) begin
            ev = 7'h01 << i;
            @(negedge core_clk);
            expect_out(6'h01 << SLOT[i], LEC_SEV_CORR);
        end
        ev = 7'h00;
        chk_vec(err_sticky, 6'h1f, "sticky set");
        clear_all();
        ev = 7'h14;
        @(negedge core_clk);
        ev = 7'h00;
        expect_out(6'h06, LEC_SEV_CORR);
        @(negedge core_clk);
        expect_out(6'h00, LEC_SEV_NONE);
        clear_all();
    endtask

    // all eight status codes across the lanes, then a lane out of l0
    task automatic t_rx;
        for (int c = 0; c < 9; c++) begin
            ph_lane = 3'(7 - c);
            ph_code = (c == 8) ? 3'h4 : c[2:0];
            l0_mask = (c == 8) ? 8'h7f : 8'hff;
            ph_go   = 1'b1;
            @(negedge core_clk);
            ph_go = 1'b0;
            @(negedge core_clk);
            if (c >= 4 && c < 8) begin
                expect_out(6'h01, LEC_SEV_CORR);
            end else begin
                expect_out(6'h00, LEC_SEV_NONE);
            end
        end
        l0_mask = 8'hff;
        clear_all();
    endtask

    // ack sequence inside and outside the unacknowledged window
    task automatic t_ack;
        logic [11:0] o [6];
        logic [11:0] x [6];
        logic [11:0] q [6];
        o = '{12'h00a, 12'h00a, 12'h00a, 12'h00a, 12'h000, 12'h000};
        x = '{12'h014, 12'h014, 12'h014, 12'h014, 12'h003, 12'h003};
        q = '{12'h009, 12'h013, 12'h014, 12'h008, 12'hfff, 12'hffe};
        for (int k = 0; k < 6; k++) begin
            oldest  = o[k];
            nxt     = x[k];
            ack_seq = q[k];
            ack_go  = 1'b1;
            @(negedge core_clk);
            if (k == 2 || k == 3 || k == 5) begin
                expect_out(6'h20, LEC_SEV_FATAL);
            end else begin
                expect_out(6'h00, LEC_SEV_NONE);
            end
        end
        chk_vec(err_sticky, 6'h20, "fatal sticky");
        // a correctable and a fatal error in one cycle report the worst
        ev = 7'h01;
        @(negedge core_clk);
        ev     = 7'h00;
        ack_go = 1'b0;
        chk_vec(err_event, 6'h21, "mixed event");
        chk_sev(err_severity, LEC_SEV_FATAL);
        chk_vec({3'h0, corr_err, nonfatal_err, fatal_err},
                6'h05, "mixed class");
        clear_all();
    endtask

    // sticky holds, clears on request, and a new event beats the clear
    task automatic t_sticky;
        ev = 7'h10;
        @(negedge core_clk);
        ev = 7'h00;
        repeat (3) @(negedge core_clk);
        chk_vec(err_sticky, 6'h04, "sticky hold");
        clr = 6'h04;
        @(negedge core_clk);
        chk_vec(err_sticky, 6'h00, "sticky cleared");
        ev  = 7'h10;
        @(negedge core_clk);
        ev  = 7'h00;
        clr = 6'h00;
        chk_vec(err_sticky, 6'h04, "set over clear");
        // a reset in mid-run drops a set sticky bit
        rst = 1'b1;
        @(negedge core_clk);
        rst = 1'b0;
        chk_vec(err_sticky, 6'h00, "sticky reset");
        @(negedge core_clk);
        expect_out(6'h00, LEC_SEV_NONE);
    endtask

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        t_reset();
        t_direct();
        t_rx();
        t_ack();
        t_sticky();
        test_done();
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        n_errors++;
        test_done();
    end
endmodule
